// *** spl_host.sv ***
// Controller that loads a chain of latch devices from a frame word.
// Assumes one clk_in; pin edges are paced by a divider enable.
module spl_host
#(
    parameter int DEVICES = 2
)
(
    input  wire logic                      clk_in,
    input  wire logic                      rstn_in,
    spl_if.host                            pins,
    input  wire logic [DEVICES*8-1:0]      frame_in,
    input  wire logic                      load_in,
    input  wire logic                      blank_in,
    input  wire logic [7:0]                dim_in,
    output logic                           busy_out
);
    localparam int TOTAL = DEVICES * spl_pkg::STAGE_W;
    localparam int CW    = $clog2(TOTAL + 1);
    initial if (DEVICES < 1) $error("DEVICES must be at least 1");

    spl_pkg::spl_ctl_e st_r, st_nxt;
    logic [TOTAL-1:0] data_r, data_nxt;
    logic [CW-1:0]    cnt_r, cnt_nxt;
    logic [1:0]       div_r;
    logic [7:0]       pwm_r;
    logic             tick, ser_r, ser_nxt, sck_r, sck_nxt;
    logic             rck_r, rck_nxt, clr_r, clr_nxt, oe_r, oe_nxt, busy_nxt;
    logic             init_r, init_nxt;

    assign tick = (div_r == 2'(spl_pkg::SHIFT_DIV - 1));

    always_comb
    begin
        st_nxt   = st_r;
        data_nxt = data_r;
        cnt_nxt  = cnt_r;
        ser_nxt  = ser_r;
        sck_nxt  = 1'b0;
        rck_nxt  = 1'b0;
        clr_nxt  = 1'b1;
        init_nxt = init_r;
        if (tick)
        begin
            case (st_r)
                spl_pkg::CTL_CLEAR:
                begin
                    clr_nxt = 1'b0;
                    st_nxt  = spl_pkg::CTL_XFER;
                end
                spl_pkg::CTL_XFER:
                begin
                    rck_nxt = 1'b1;
                    st_nxt  = spl_pkg::CTL_IDLE;
                end
                spl_pkg::CTL_IDLE:
                begin
                    init_nxt = 1'b0;
                    if (load_in || blank_in)
                    begin
                        data_nxt = blank_in ? '0 : frame_in;
                        cnt_nxt  = CW'(TOTAL);
                        st_nxt   = spl_pkg::CTL_SHIFT_LO;
                    end
                end
                spl_pkg::CTL_SHIFT_LO:
                begin
                    ser_nxt = data_r[TOTAL-1];
                    st_nxt  = spl_pkg::CTL_SHIFT_HI;
                end
                spl_pkg::CTL_SHIFT_HI:
                begin
                    sck_nxt  = 1'b1;
                    data_nxt = {data_r[TOTAL-2:0], 1'b0};
                    cnt_nxt  = cnt_r - CW'(1);
                    st_nxt   = (cnt_r == CW'(1)) ? spl_pkg::CTL_STORE
                                                 : spl_pkg::CTL_SHIFT_LO;
                end
                spl_pkg::CTL_STORE:
                begin
                    rck_nxt = 1'b1;
                    st_nxt  = spl_pkg::CTL_IDLE;
                end
                default: st_nxt = spl_pkg::CTL_IDLE;
            endcase
        end
        else
        begin
            sck_nxt = sck_r;
            rck_nxt = rck_r;
            clr_nxt = clr_r;
        end
        oe_nxt   = init_nxt | (pwm_r >= dim_in);
        busy_nxt = (st_nxt != spl_pkg::CTL_IDLE);
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            st_r     <= spl_pkg::CTL_CLEAR;
            data_r   <= '0;
            cnt_r    <= '0;
            div_r    <= 2'h0;
            pwm_r    <= 8'h00;
            ser_r    <= 1'b0;
            sck_r    <= 1'b0;
            rck_r    <= 1'b0;
            clr_r    <= 1'b1;
            oe_r     <= 1'b1;
            init_r   <= 1'b1;
            busy_out <= 1'b1;
        end
        else
        begin
            st_r     <= st_nxt;
            data_r   <= data_nxt;
            cnt_r    <= cnt_nxt;
            div_r    <= tick ? 2'h0 : div_r + 2'h1;
            pwm_r    <= pwm_r + 8'h01;
            ser_r    <= ser_nxt;
            sck_r    <= sck_nxt;
            rck_r    <= rck_nxt;
            clr_r    <= clr_nxt;
            oe_r     <= oe_nxt;
            init_r   <= init_nxt;
            busy_out <= busy_nxt;
        end
    end

    assign pins.serial_in     = ser_r;
    assign pins.shift_clock   = sck_r;
    assign pins.store_clock   = rck_r;
    assign pins.shift_clear_n = clr_r;
    assign pins.out_enable_n  = oe_r;
endmodule // spl_host

// *** spl_pkg.sv ***
// Package for the serial-in parallel-out latch and its controller.
// Assumes a single 100 MHz system clock shared by both ends.
package spl_pkg;
    localparam int          STAGE_W      = 8;
    localparam logic [7:0]  BLANK_BYTE   = 8'h00;
    localparam logic [7:0]  CLEAR_BYTE   = 8'h00;
    localparam real         CLK_MHZ      = 100.0;
    localparam int          SHIFT_DIV    = 4;
    localparam int          DIM_STEPS    = 256;
    typedef enum logic [2:0] {
        CTL_CLEAR,
        CTL_XFER,
        CTL_IDLE,
        CTL_SHIFT_LO,
        CTL_SHIFT_HI,
        CTL_STORE
    } spl_ctl_e;
endpackage : spl_pkg

// *** spl_if.sv ***
// Interface joining the controller to a chain of latch devices.
// Pins are plain wires; the clocks are level signals sampled on clk.
interface spl_if;
    logic serial_in;
    logic shift_clock;
    logic store_clock;
    logic shift_clear_n;
    logic out_enable_n;
    logic cascade_out;
    modport dev  (input  serial_in, shift_clock, store_clock,
                  input  shift_clear_n, out_enable_n,
                  output cascade_out);
    modport host (output serial_in, shift_clock, store_clock,
                  output shift_clear_n, out_enable_n,
                  input  cascade_out);
endinterface : spl_if

// *** spl_dev.sv ***
// One eight-stage latch device, modelled synchronously on clk_in.
// Assumes pin inputs come from another domain; each passes two flops.
// How it works
// - Host wires cascade to next serial input (nothing here does: spl_host leaves pins.cascade_out unread)
// - Any number of devices may chain
// - Storage holds while shift register changes
// - No power-up state without clear
// - Host clears, then stores, at start
// - Clear forces all shift stages zero
// - Host may keep outputs off initially
// - Host may dim with enable PWM
// - Host may blank by loading zeros
// - Shift edge: stage0 takes serial input
// - Store edge outside clear: storage loads shift register
// - Simultaneous edges store pre-shift data
module spl_dev
#(
    parameter int WIDTH = spl_pkg::STAGE_W
)
(
    input  wire logic             clk_in,
    input  wire logic             rstn_in,
    spl_if.dev                    pins,
    output logic [WIDTH-1:0]      par_out,
    output logic [WIDTH-1:0]      par_oe_out
);
    // The shift path slices WIDTH-2, so a single stage cannot be served
    if (WIDTH < 2)
    begin : g_width_check
        $error("WIDTH must be at least 2");
    end

    logic [4:0] s1_r, s2_r, s3_r;
    logic [WIDTH-1:0] shift_r, shift_nxt, store_r, store_nxt;
    logic [WIDTH-1:0] oe_r, oe_nxt;
    logic casc_r, casc_nxt;
    logic sh_edge, st_edge;

    // Two-flop synchronisers, third stage for edge detection
    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            s1_r <= 5'h1c;
            s2_r <= 5'h1c;
            s3_r <= 5'h1c;
        end
        else
        begin
            s1_r <= {pins.shift_clear_n, pins.out_enable_n, pins.serial_in,
                     pins.store_clock, pins.shift_clock};
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign sh_edge = s2_r[0] & ~s3_r[0];
    assign st_edge = s2_r[1] & ~s3_r[1];

    always_comb
    begin
        shift_nxt = shift_r;
        store_nxt = store_r;
        if (st_edge && s2_r[4])
            store_nxt = shift_r;
        if (!s2_r[4])
            shift_nxt = '0;
        else if (sh_edge)
            shift_nxt = {shift_r[WIDTH-2:0], s2_r[2]};
        oe_nxt   = {WIDTH{~s2_r[3]}};
        casc_nxt = shift_nxt[WIDTH-1];
    end

    // Data registers carry no reset: power-up content is undefined
    always_ff @(posedge clk_in)
    begin
        shift_r <= shift_nxt;
        store_r <= store_nxt;
        par_out <= store_nxt;
        casc_r  <= casc_nxt;
    end

    always_ff @(posedge clk_in or negedge rstn_in)
    begin
        if (!rstn_in)
            oe_r <= '0;
        else
            oe_r <= oe_nxt;
    end

    assign par_oe_out       = oe_r;
    assign pins.cascade_out = casc_r;
endmodule // spl_dev

// *** spl_properties.sv ***
// Checks on the pin interface between controller and latch device.
// Assumes one clk_in domain and rstn_in active low.
module spl_properties (
    input wire logic       clk_in,
    input wire logic       rstn_in,
    input wire logic       shift_clock,
    input wire logic       store_clock,
    input wire logic       shift_clear_n,
    input wire logic       out_enable_n,
    input wire logic       cascade_out,
    input wire logic [7:0] par_out,
    input wire logic [7:0] par_oe_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    property p_clr; $fell(shift_clear_n) |-> ##3 !cascade_out; endproperty
    a_clr: assert property (p_clr)
        else $error("clear missed");
    property p_clr_hold; !shift_clear_n[*4] |-> !cascade_out; endproperty
    a_clr_hold: assert property (p_clr_hold)
        else $error("clear overridden");
    property p_oe_off; out_enable_n[*4] |-> par_oe_out == 8'h00; endproperty
    a_oe_off: assert property (p_oe_off)
        else $error("outputs not off");
    property p_oe_all; par_oe_out == 8'h00 || &par_oe_out; endproperty
    a_oe_all: assert property (p_oe_all)
        else $error("outputs split");
    property p_hold; !store_clock[*5] |-> par_out === $past(par_out); endproperty
    a_hold: assert property (p_hold)
        else $error("storage moved");
    property p_casc;
        (!shift_clock && shift_clear_n)[*5] |-> $stable(cascade_out);
    endproperty
    a_casc: assert property (p_casc)
        else $error("cascade moved");
    property p_store;
        $rose(store_clock) && shift_clear_n && !shift_clock
            |-> ##3 par_out[7] === cascade_out;
    endproperty
    a_store: assert property (p_store)
        else $error("store wrong");
    property p_init; $fell(shift_clear_n) |-> ##[1:16] $rose(store_clock);
    endproperty
    a_init: assert property (p_init)
        else $error("no store after clear");
    c_shift: cover property ($rose(shift_clock));
    c_store: cover property ($rose(store_clock));
    c_oe: cover property ($fell(out_enable_n));
endmodule // spl_properties

// *** spl_bench.sv ***
// Bench joining the controller to one latch device.
// Assumes 100 MHz clock; expectations come from frames driven.
module spl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk_in = 1'b0;
    logic       rstn_in = 1'b0;
    logic [7:0] frame_in = 8'h00;
    logic       load_in = 1'b0;
    logic       blank_in = 1'b0;
    logic [7:0] dim_in = 8'hff;
    logic       busy_out;
    logic [7:0] par_out;
    logic [7:0] par_oe_out;
    int         n_errors = 0;
    int         n_checks = 0;
    int         seed = 39472;
    int         k;
    spl_if pins ();
    spl_host #(.DEVICES(1)) i_spl_host (.clk_in(clk_in), .rstn_in(rstn_in),
        .pins(pins), .frame_in(frame_in), .load_in(load_in),
        .blank_in(blank_in), .dim_in(dim_in), .busy_out(busy_out));
    spl_dev i_spl_dev (.clk_in(clk_in), .rstn_in(rstn_in), .pins(pins),
        .par_out(par_out), .par_oe_out(par_oe_out));
    spl_properties i_spl_properties (.clk_in(clk_in), .rstn_in(rstn_in),
        .shift_clock(pins.shift_clock), .store_clock(pins.store_clock),
        .shift_clear_n(pins.shift_clear_n), .cascade_out(pins.cascade_out),
        .out_enable_n(pins.out_enable_n), .par_out(par_out),
        .par_oe_out(par_oe_out));
    always #5 clk_in = ~clk_in;
    task automatic wrap_up();
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 300 && busy_out !== lvl; i++)
            tick(1);
        if (busy_out !== lvl)
        begin
            n_errors++;
            wrap_up();
        end
    endtask
    // Old pattern must stay visible while the new one shifts in
    task automatic load(input logic [7:0] f, input logic blank);
        logic [7:0] old;
        wait_busy(1'b0);
        // The store that ends a load reaches par_out 3 clocks after idle
        tick(4);
        old = par_out;
        frame_in = f;
        blank_in = blank;
        load_in = 1'b1;
        wait_busy(1'b1);
        load_in = 1'b0;
        blank_in = 1'b0;
        tick(20);
        chk("hold", old, par_out);
        wait_busy(1'b0);
        tick(4);
        chk("par", blank ? 8'h00 : f, par_out);
        chk("casc", {7'h00, ~blank & f[7]},
            {7'h00, pins.cascade_out});
    endtask
    initial
    begin
        tick(4);
        rstn_in = 1'b1;
        load(8'h80, 1'b0);
        load(8'h01, 1'b0);
        for (k = 0; k < 6; k++)
            load(8'($random(seed)), 1'b0);
        load(8'h5a, 1'b1);
        dim_in = 8'h00;
        load(8'h81, 1'b0);
        chk("oe_off", 8'h00, par_oe_out);
        dim_in = 8'h80;
        tick(8);
        k = 0;
        repeat (256)
        begin
            tick(1);
            k += int'(par_oe_out === 8'hff);
        end
        chk("dim", 8'h80, 8'(k));
        rstn_in = 1'b0;
        tick(2);
        rstn_in = 1'b1;
        wait_busy(1'b0);
        tick(4);
        chk("init", 8'h00, par_out);
        wrap_up();
    end
endmodule // spl_bench
